// [common/uart_irq_pkg.sv]
// constants for the uart interrupt level and mask block
// assumes an apb slave with 32-bit data, one clock, synchronous reset
package uart_irq_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_TRIG_LEVEL  = 8'h34;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h38;
  localparam logic [7:0]  OFS_RAW_STATUS  = 8'h3c;
  localparam logic [7:0]  OFS_MASKED_STAT = 8'h40;
  localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h44;
  localparam int          TX_TRIG_LSB     = 0;
  localparam int          RX_TRIG_LSB     = 3;
  localparam int          TRIG_W          = 3;
  localparam logic [2:0]  TRIG_RESET      = 3'h2;
  localparam logic [2:0]  TRIG_RESERVED   = 3'h7;
  localparam int          SRC_W           = 13;
  localparam logic [12:0] SRC_VALID       = 13'h1ff2;
  localparam logic [12:0] MASK_RESET      = 13'h0000;
  localparam int          BIT_CTS         = 1;
  localparam int          BIT_RX_LEVEL    = 4;
  localparam int          BIT_TX_LEVEL    = 5;
  localparam int          BIT_RX_TIMEOUT  = 6;
  localparam int          BIT_FRAMING     = 7;
  localparam int          BIT_PARITY      = 8;
  localparam int          BIT_BREAK       = 9;
  localparam int          BIT_OVERRUN     = 10;
  localparam int          BIT_XOFF        = 11;
  localparam int          BIT_TX_EMPTY    = 12;
  localparam int          FIFO_DEPTH      = 64;
  localparam int          LEVEL_W         = 7;
endpackage

// [rtl/uart_event_latch.sv]
// one sticky interrupt status bit: event sets, write-one clears
// set wins over clear in the same cycle so no event is lost
`timescale 1ns/1ps
`default_nettype none
module uart_event_latch (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_pend
);
  logic pend;
  logic next_pend;
  always_comb begin
    next_pend = i_set | (pend & ~i_clr);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pend <= 1'b0;
    end else begin
      pend <= next_pend;
    end
  end
  assign o_pend = pend;
endmodule
`default_nettype wire

// [rtl/uart_fifo_threshold.sv]
// compares one fifo fill or space count against a trigger code
// assumes level is a plain count on the same clock, 0..depth
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_threshold
  import uart_irq_pkg::*;
#(
  parameter int DEPTH = uart_irq_pkg::FIFO_DEPTH
) (
  input  wire logic [uart_irq_pkg::TRIG_W-1:0]  i_code,
  input  wire logic [uart_irq_pkg::LEVEL_W-1:0] i_level,
  output logic                                  o_reached
);
  logic [LEVEL_W-1:0] thresh;
  always_comb begin
    // code 7 reserved: behave as reset code
    unique case ((i_code == TRIG_RESERVED) ? TRIG_RESET : i_code)
      3'h0:    thresh = LEVEL_W'(DEPTH / 64);
      3'h1:    thresh = LEVEL_W'(DEPTH / 32);
      3'h2:    thresh = LEVEL_W'(DEPTH / 16);
      3'h3:    thresh = LEVEL_W'(DEPTH / 8);
      3'h4:    thresh = LEVEL_W'(DEPTH / 4);
      3'h5:    thresh = LEVEL_W'(DEPTH / 2);
      default: thresh = LEVEL_W'((DEPTH * 3) / 4);
    endcase
    o_reached = (i_level >= thresh);
  end
endmodule
`default_nettype wire

// [rtl/uart_irq_level_and_mask.sv]
// uart interrupt trigger levels, enable mask, status and clear, apb slave
// assumes raw events and fifo levels come from logic on i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module uart_irq_level_and_mask
  import uart_irq_pkg::*;
#(
  parameter int DEPTH = uart_irq_pkg::FIFO_DEPTH
) (
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_psel,
  input  wire logic                                i_penable,
  input  wire logic                                i_pwrite,
  input  wire logic [uart_irq_pkg::ADDR_W-1:0]     i_paddr,
  input  wire logic [uart_irq_pkg::DATA_W-1:0]     i_pwdata,
  output logic [uart_irq_pkg::DATA_W-1:0]          o_prdata,
  output logic                                     o_pready,
  output logic                                     o_pslverr,
  input  wire logic [uart_irq_pkg::SRC_W-1:0]      i_raw_event,
  input  wire logic [uart_irq_pkg::LEVEL_W-1:0]    i_tx_fifo_space,
  input  wire logic [uart_irq_pkg::LEVEL_W-1:0]    i_rx_fifo_fill,
  output logic [uart_irq_pkg::TRIG_W-1:0]          o_tx_trigger_level,
  output logic [uart_irq_pkg::TRIG_W-1:0]          o_rx_trigger_level,
  output logic [uart_irq_pkg::SRC_W-1:0]           o_masked_status,
  output logic                                     o_uart_irq
);
  import uart_irq_pkg::*;

  typedef struct packed {
    logic [TRIG_W-1:0] tx_trigger_level;
    logic [TRIG_W-1:0] rx_trigger_level;
    logic [SRC_W-1:0]  interrupt_enable_mask;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
    logic              irq;
    logic              tx_lvl_q;
    logic              rx_lvl_q;
  } state_t;

  state_t st;
  state_t next_st;

  logic              access;
  logic              wr;
  logic              rd;
  logic              tx_reached;
  logic              rx_reached;
  logic [SRC_W-1:0]  events;
  logic [SRC_W-1:0]  clr;
  logic [SRC_W-1:0]  pend;
  logic [SRC_W-1:0]  masked;
  logic              addr_ok;

  // zero wait states: pready tied high, every access done in its access phase
  assign access = i_psel & i_penable;
  assign wr     = access & i_pwrite;
  assign rd     = access & ~i_pwrite;
  assign addr_ok = (i_paddr == OFS_TRIG_LEVEL) || (i_paddr == OFS_IRQ_MASK)
                || (i_paddr == OFS_RAW_STATUS) || (i_paddr == OFS_MASKED_STAT)
                || (i_paddr == OFS_IRQ_CLEAR);

  uart_fifo_threshold #(.DEPTH(DEPTH)) u_tx_thr (
    .i_code    (st.tx_trigger_level),
    .i_level   (i_tx_fifo_space),
    .o_reached (tx_reached)
  );

  uart_fifo_threshold #(.DEPTH(DEPTH)) u_rx_thr (
    .i_code    (st.rx_trigger_level),
    .i_level   (i_rx_fifo_fill),
    .o_reached (rx_reached)
  );

  // level crossings are edge events so a cleared level irq stays cleared
  always_comb begin
    events = i_raw_event & SRC_VALID;
    events[BIT_TX_LEVEL] = i_raw_event[BIT_TX_LEVEL] | (tx_reached & ~st.tx_lvl_q);
    events[BIT_RX_LEVEL] = i_raw_event[BIT_RX_LEVEL] | (rx_reached & ~st.rx_lvl_q);
  end

  // clear register: only the valid source bits act
  assign clr = (wr && i_paddr == OFS_IRQ_CLEAR) ? (i_pwdata[SRC_W-1:0] & SRC_VALID)
                                                : '0;

  genvar g;
  generate
    for (g = 0; g < SRC_W; g++) begin : g_src
      if (SRC_VALID[g]) begin : g_on
        uart_event_latch u_latch (
          .i_ref_clk (i_ref_clk),
          .i_rst     (i_rst),
          .i_set     (events[g]),
          .i_clr     (clr[g]),
          .o_pend    (pend[g])
        );
      end else begin : g_off
        assign pend[g] = 1'b0;
      end
    end
  endgenerate

  assign masked = pend & st.interrupt_enable_mask;

  always_comb begin
    next_st          = st;
    next_st.tx_lvl_q = tx_reached;
    next_st.rx_lvl_q = rx_reached;
    next_st.irq      = |masked;
    next_st.slverr   = 1'b0;
    if (wr) begin
      unique case (i_paddr)
        OFS_TRIG_LEVEL: begin
          next_st.tx_trigger_level = i_pwdata[TX_TRIG_LSB +: TRIG_W];
          next_st.rx_trigger_level = i_pwdata[RX_TRIG_LSB +: TRIG_W];
        end
        OFS_IRQ_MASK: begin
          // reserved positions dropped on write
          // enables at 1 and 4..12
          next_st.interrupt_enable_mask = i_pwdata[SRC_W-1:0] & SRC_VALID;
        end
        default: begin
          next_st.slverr = ~addr_ok;
        end
      endcase
    end
    if (rd) begin
      next_st.rdata = '0;
      unique case (i_paddr)
        OFS_TRIG_LEVEL: begin
          next_st.rdata[TX_TRIG_LSB +: TRIG_W] = st.tx_trigger_level;
          next_st.rdata[RX_TRIG_LSB +: TRIG_W] = st.rx_trigger_level;
        end
        OFS_IRQ_MASK:    next_st.rdata[SRC_W-1:0] = st.interrupt_enable_mask;
        OFS_RAW_STATUS:  next_st.rdata[SRC_W-1:0] = pend;
        OFS_MASKED_STAT: next_st.rdata[SRC_W-1:0] = masked;
        default: begin
          next_st.slverr = ~addr_ok;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st                       <= '0;
      st.tx_trigger_level      <= TRIG_RESET;
      st.rx_trigger_level      <= TRIG_RESET;
      st.interrupt_enable_mask <= MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // read data is combinational over the register so it is valid in the access phase
  always_comb begin
    o_prdata = '0;
    if (rd) begin
      unique case (i_paddr)
        OFS_TRIG_LEVEL: begin
          o_prdata[TX_TRIG_LSB +: TRIG_W] = st.tx_trigger_level;
          o_prdata[RX_TRIG_LSB +: TRIG_W] = st.rx_trigger_level;
        end
        OFS_IRQ_MASK:    o_prdata[SRC_W-1:0] = st.interrupt_enable_mask;
        OFS_RAW_STATUS:  o_prdata[SRC_W-1:0] = pend;
        OFS_MASKED_STAT: o_prdata[SRC_W-1:0] = masked;
        default:         o_prdata = '0;
      endcase
    end
  end

  assign o_pready           = 1'b1;
  assign o_pslverr          = access & ~addr_ok;
  assign o_tx_trigger_level = st.tx_trigger_level;
  assign o_rx_trigger_level = st.rx_trigger_level;
  assign o_masked_status    = masked;
  assign o_uart_irq         = |masked;

  // checks
  property p_trig_reset;
    @(posedge i_ref_clk) $fell(i_rst) |->
      (st.tx_trigger_level == TRIG_RESET) && (st.rx_trigger_level == TRIG_RESET);
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("trigger reset wrong");

  property p_rx_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr && i_paddr == OFS_TRIG_LEVEL) |=>
        st.rx_trigger_level == $past(i_pwdata[5:3]);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("rx trigger not written");

  property p_mask_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr && i_paddr == OFS_IRQ_MASK) |=>
        st.interrupt_enable_mask == ($past(i_pwdata[SRC_W-1:0]) & SRC_VALID);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_cts_pos;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr && i_paddr == OFS_IRQ_MASK && i_pwdata[1]) |=> st.interrupt_enable_mask[1];
  endproperty
  a_cts_pos: assert property (p_cts_pos) else $error("cts enable misplaced");

  property p_masked;
    @(posedge i_ref_clk) disable iff (i_rst)
      masked[BIT_FRAMING] == (pend[BIT_FRAMING] && st.interrupt_enable_mask[7]);
  endproperty
  a_masked: assert property (p_masked) else $error("masked status wrong");

  property p_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      (wr && i_paddr == OFS_IRQ_CLEAR && i_pwdata[8] && !events[8]) |=> !pend[8];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_set_wins;
    @(posedge i_ref_clk) disable iff (i_rst)
      events[10] |=> pend[10];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
      (rd && i_paddr == OFS_IRQ_MASK) |-> (o_prdata[31:13] == '0) && (o_prdata[0] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_irq;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_uart_irq == (|(pend & st.interrupt_enable_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq output wrong");

  c_irq:   cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_uart_irq));
  c_clear: cover property (@(posedge i_ref_clk) disable iff (i_rst) (clr != '0) ##1 !o_uart_irq);
  c_tx:    cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(tx_reached));
endmodule
`default_nettype wire

// [sim/tb_uart_irq_level_and_mask.sv]
// self-checking bench for the uart interrupt level and mask block
// assumes apb with zero wait states and a behavioural peer model
`timescale 1ns/1ps
`default_nettype none
module tb_uart_irq_level_and_mask;
  import uart_irq_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [12:0] raw_event;
  logic [12:0] mstat;
  logic [6:0]  tx_space;
  logic [6:0]  rx_fill;
  logic [2:0]  tx_trig;
  logic [2:0]  rx_trig;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          stat      = 0;
  int          mask      = 0;
  int          ev;
  int          thr;
  always #2.5 i_ref_clk = ~i_ref_clk;
  uart_irq_level_and_mask u_uart_irq_level_and_mask (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_raw_event(raw_event),
    .i_tx_fifo_space(tx_space), .i_rx_fifo_fill(rx_fill),
    .o_tx_trigger_level(tx_trig), .o_rx_trigger_level(rx_trig),
    .o_masked_status(mstat), .o_uart_irq(irq));
  uart_peer_model u_uart_peer_model (
    .i_ref_clk(i_ref_clk), .o_raw_event(raw_event),
    .o_tx_fifo_space(tx_space), .o_rx_fifo_fill(rx_fill));
  task automatic conclude();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic stat_chk();
    rdchk(OFS_RAW_STATUS, 32'(stat));
    rdchk(OFS_MASKED_STAT, 32'(stat & mask));
    @(negedge i_ref_clk);
    chk({19'h0, mstat}, 32'(stat & mask));
    chk({31'h0, irq}, {31'h0, (stat & mask) != 0});
  endtask
  initial begin
    void'($urandom(51846));
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rdchk(OFS_TRIG_LEVEL, 32'h12);
    rdchk(OFS_IRQ_MASK, 32'h0);
    stat_chk();
    rdchk(8'h50, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (int b = 0; b < 13; b++) begin
      apb(1'b1, OFS_IRQ_MASK, 32'h1 << b);
      rdchk(OFS_IRQ_MASK, (32'h1ff2 >> b) & 1 ? 32'h1 << b : 32'h0);
    end
    $display("test mask bits done");
    for (int i = 0; i < 24; i++) begin
      mask = $urandom;
      apb(1'b1, OFS_IRQ_MASK, 32'(mask));
      mask &= 32'h1ff2;
      rdchk(OFS_IRQ_MASK, 32'(mask));
      ev = $urandom;
      u_uart_peer_model.pulse(13'(ev));
      stat |= ev & 32'h1ff2;
      stat_chk();
      ev = $urandom;
      apb(1'b1, OFS_IRQ_CLEAR, 32'(ev));
      stat &= ~ev;
      stat_chk();
    end
    rdchk(OFS_IRQ_CLEAR, 32'h0);
    $display("test events done");
    apb(1'b1, OFS_IRQ_MASK, 32'h30);
    mask = 32'h30;
    for (int c = 0; c < 8; c++) begin
      thr = (c == 6) ? 48 : (c == 7) ? 4 : (1 << c);
      u_uart_peer_model.levels(0, 0);
      apb(1'b1, OFS_TRIG_LEVEL, 32'(c | (c << 3)));
      @(negedge i_ref_clk);
      chk({26'h0, rx_trig, tx_trig}, 32'(c | (c << 3)));
      apb(1'b1, OFS_IRQ_CLEAR, 32'h1ff2);
      stat = 0;
      u_uart_peer_model.levels(thr - 1, thr - 1);
      stat_chk();
      u_uart_peer_model.levels(thr, thr);
      stat = 32'h30;
      stat_chk();
    end
    $display("test trigger levels done");
    conclude();
  end
endmodule
`default_nettype wire

// [sim/uart_peer_model.sv]
// stand-in for the uart datapath: raw events and fifo levels
// assumes the bench calls its tasks on the i_ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module uart_peer_model
  import uart_irq_pkg::*;
(
  input  wire logic                             i_ref_clk,
  output logic [uart_irq_pkg::SRC_W-1:0]        o_raw_event,
  output logic [uart_irq_pkg::LEVEL_W-1:0]      o_tx_fifo_space,
  output logic [uart_irq_pkg::LEVEL_W-1:0]      o_rx_fifo_fill
);
  initial begin
    o_raw_event     = '0;
    o_tx_fifo_space = '0;
    o_rx_fifo_fill  = '0;
  end
  // events last one cycle, like the real error strobes
  task automatic pulse(input logic [SRC_W-1:0] ev);
    @(posedge i_ref_clk);
    o_raw_event <= ev;
    @(posedge i_ref_clk);
    o_raw_event <= '0;
  endtask
  task automatic levels(input int tx, input int rx);
    @(posedge i_ref_clk);
    o_tx_fifo_space <= LEVEL_W'(tx);
    o_rx_fifo_fill  <= LEVEL_W'(rx);
  endtask
endmodule
`default_nettype wire
